// [cvst_top.sv]
// video source timing generator toward a camera link frame grabber
`timescale 1ns/10ps
`default_nettype none
module cvst_top #(
   parameter int FIFO_DEPTH = cvst_pkg::CVST_FIFO_DEPTH,
   parameter int LEVEL_W    = 16
) (
   input  wire logic                  clock,
   input  wire logic                  srst,
   input  wire cvst_pkg::cvst_ctrl_s  ctrl,
   input  wire cvst_pkg::cvst_geom_s  geom,
   input  wire logic [LEVEL_W-1:0]    host_buffered_words,
   input  wire logic [31:0]           dma_data,
   input  wire logic                  dma_valid,
   output logic                       dma_ready,
   input  wire logic                  cc1,
   input  wire logic                  cc2,
   output cvst_pkg::cvst_video_s      video,
   output logic                       running
);
   import cvst_pkg::*;

   // ------------------------------------------------------------
   // fifo in the data path
   // ------------------------------------------------------------
   localparam int LVW = $clog2(FIFO_DEPTH + 1);
   logic [31:0]    fifo_data;
   logic           fifo_valid;
   wire            fifo_pop;
   wire            fifo_push = dma_valid && dma_ready;
   logic [LVW-1:0] fifo_level;

   cvst_fifo #(
      .WIDTH (CVST_DW),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clock     (clock),
      .srst      (srst),
      .clear     (ctrl.fifo_reset),
      .in_data   (dma_data),
      .in_valid  (fifo_push),
      .in_ready  (),
      .out_data  (fifo_data),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop),
      .level     (fifo_level)
   );

   // ------------------------------------------------------------
   // ready toward the dma side
   // ------------------------------------------------------------
   // ready is a flop, so it looks one edge ahead: room after this edge's push and pop
   // a word offered in the first stopped cycle is dropped by the clear
   wire [LVW-1:0] level_next = fifo_level + LVW'(fifo_push) - LVW'(fifo_pop);
   wire           room_next  = (level_next < LVW'(FIFO_DEPTH));

   always_ff @(posedge clock)
   begin
      if (srst || ctrl.fifo_reset)
      begin
         dma_ready <= 1'b0;
      end
      else
      begin
         dma_ready <= room_next;
      end
   end

   // ------------------------------------------------------------
   // start threshold
   // ------------------------------------------------------------
   // host side buffering is counted upstream; the small fifo just adds its level
   wire [15:0] thresh     = ctrl.small_image ? CVST_SMALL_WORDS : CVST_LARGE_WORDS;
   wire [16:0] buffered   = 17'(host_buffered_words) + 17'(fifo_level);
   wire        thresh_ok  = ctrl.internal_data || (buffered >= 17'(thresh));
   logic       started;

   // ------------------------------------------------------------
   // trigger: sync then edge detect
   // ------------------------------------------------------------
   logic trig_meta;
   logic trig_sync;
   logic trig_prev;

   // one polarity decode serves both the current and the delayed sample
   function automatic logic active_level(input logic pin, input logic high_true);
      active_level = high_true ? pin : !pin;
   endfunction

   wire  trig_raw   = ctrl.trig_from_cc2 ? cc2 : cc1;
   wire  trig_level = active_level(trig_sync, ctrl.trig_active_high);
   wire  trig_prevl = active_level(trig_prev, ctrl.trig_active_high);
   wire  trig_edge  = trig_level && !trig_prevl;

   // cleared on reset so a short reset leaves no unknown edge behind
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         trig_meta <= 1'b0;
         trig_sync <= 1'b0;
         trig_prev <= 1'b0;
      end
      else
      begin
         trig_meta <= trig_raw;
         trig_sync <= trig_meta;
         trig_prev <= trig_sync;
      end
   end

   // ------------------------------------------------------------
   // timing limits
   // ------------------------------------------------------------
   function automatic logic [15:0] end_of(input logic [15:0] s, input logic [15:0] e,
                                          input logic [15:0] w);
      end_of = (e == CVST_POS_RST) ? 16'(s + w) : e;
   endfunction

   wire [15:0] fv_end_eff = end_of(geom.fv_start, geom.fv_end, geom.width_clocks);
   wire [15:0] lv_end_eff = end_of(geom.lv_start, geom.lv_end, geom.width_clocks);
   wire [15:0] rv_end_eff = end_of(geom.rv_start, geom.rv_end, geom.width_clocks);
   wire [15:0] line_len   = (geom.hblank != 16'h0000) ?
                            16'(geom.width_clocks + geom.hblank) : geom.total_width;
   wire [15:0] frame_len  = (geom.vblank != 16'h0000) ?
                            16'(geom.height + geom.vblank) : geom.total_height;

   // ------------------------------------------------------------
   // raster state
   // ------------------------------------------------------------
   typedef enum logic [1:0] {CVST_IDLE, CVST_WAIT_FRAME, CVST_WAIT_LINE, CVST_LINE} cvst_state_e;
   cvst_state_e state;
   logic [15:0] hcnt;
   logic [15:0] vcnt;
   logic [15:0] frame_count;
   logic [15:0] data_count;
   logic        first_word;
   cvst_state_e next_frame_state;

   wire  line_end   = (hcnt == 16'(line_len - 16'h0001)) || (line_len == 16'h0000);
   wire  frame_end  = !ctrl.linescan && (vcnt == 16'(frame_len - 16'h0001));
   wire  v_active   = ctrl.linescan || (vcnt < geom.height);
   wire  fv_win     = (hcnt >= geom.fv_start) && (hcnt < fv_end_eff);
   wire  lv_win     = (hcnt >= geom.lv_start) && (hcnt < lv_end_eff);
   wire  in_line    = (state == CVST_LINE);
   wire  lv_now     = in_line && lv_win && (v_active || ctrl.line_valid_cont);
   wire  act_now    = in_line && lv_win && v_active;
   wire  before_win = ctrl.margin_fill_en && (hcnt < geom.rv_start);
   wire  after_win  = ctrl.margin_fill_en && (hcnt >= rv_end_eff);
   wire  need_img   = act_now && !before_win && !after_win;
   wire  stall      = need_img && !ctrl.internal_data && !fifo_valid;
   wire  advance    = in_line && !stall;
   assign fifo_pop  = advance && need_img && !ctrl.internal_data;
   // next frame goes straight on unless a trigger must be awaited, keeping the period exact
   assign next_frame_state = ctrl.trig_frame ? CVST_WAIT_FRAME :
                             ctrl.trig_line  ? CVST_WAIT_LINE : CVST_LINE;

   // ------------------------------------------------------------
   // data path
   // ------------------------------------------------------------
   wire [31:0] gen_word = {~data_count, data_count};
   wire [31:0] img_word = ctrl.internal_data ? gen_word : fifo_data;
   logic [31:0] ilv_word;

   // four-tap reorder of bytes within the word; full raster address tables are upstream
   genvar t;
   generate
      for (t = 0; t < CVST_TAPS; t++)
      begin : g_tap
         assign ilv_word[8*t +: 8] = ctrl.interleave_en ?
                                     img_word[8*(CVST_TAPS-1-t) +: 8] : img_word[8*t +: 8];
      end
   endgenerate

   wire [31:0] left_fill  = {4{geom.left_margin_value}};
   wire [31:0] right_fill = {4{geom.right_margin_value}};
   wire [31:0] out_word   = before_win ? left_fill :
                            after_win  ? right_fill :
                            (first_word && ctrl.frame_count_en) ?
                            {CVST_FC_MARKER, frame_count} : ilv_word;

   wire start_ok = thresh_ok || started;

   // ------------------------------------------------------------
   // sequencing
   // ------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (srst || ctrl.fifo_reset)
      begin
         state       <= CVST_IDLE;
         hcnt        <= CVST_POS_RST;
         vcnt        <= CVST_POS_RST;
         frame_count <= CVST_CNT_RST;
         data_count  <= CVST_CNT_RST;
         first_word  <= 1'b1;
         started     <= 1'b0;
      end
      else
      begin
         unique case (state)
            CVST_IDLE:
            begin
               if (start_ok)
               begin
                  started <= 1'b1;
                  state   <= CVST_WAIT_FRAME;
               end
            end
            CVST_WAIT_FRAME:
            begin
               data_count <= CVST_CNT_RST;
               first_word <= 1'b1;
               vcnt       <= CVST_POS_RST;
               hcnt       <= CVST_POS_RST;
               if (!ctrl.trig_frame || trig_edge)
               begin
                  state <= ctrl.trig_line ? CVST_WAIT_LINE : CVST_LINE;
               end
            end
            CVST_WAIT_LINE:
            begin
               hcnt <= CVST_POS_RST;
               if (trig_edge)
               begin
                  state <= CVST_LINE;
               end
            end
            CVST_LINE:
            begin
               if (advance)
               begin
                  if (need_img)
                  begin
                     data_count <= data_count + 16'h0001;
                     first_word <= 1'b0;
                  end
                  if (line_end)
                  begin
                     hcnt <= CVST_POS_RST;
                     if (frame_end)
                     begin
                        frame_count <= frame_count + 16'h0001;
                        vcnt        <= CVST_POS_RST;
                        data_count  <= CVST_CNT_RST;
                        first_word  <= 1'b1;
                        state       <= next_frame_state;
                     end
                     else
                     begin
                        vcnt  <= vcnt + 16'h0001;
                        state <= ctrl.trig_line ? CVST_WAIT_LINE : CVST_LINE;
                     end
                  end
                  else
                  begin
                     hcnt <= hcnt + 16'h0001;
                  end
               end
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // registered outputs
   // ------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (srst || ctrl.fifo_reset)
      begin
         video   <= '0;
         running <= 1'b0;
      end
      else
      begin
         running           <= (state != CVST_IDLE);
         video.frame_valid <= in_line && v_active && fv_win;
         video.line_valid  <= lv_now && !stall;
         video.data_valid  <= act_now && !stall;
         video.data        <= out_word;
      end
   end
endmodule
`default_nettype wire

// [cvst_pkg.sv]
// shared constants and types for the camera link video source timing block
package cvst_pkg;
   localparam int          CVST_DW        = 32;
   localparam int          CVST_HW        = 16;
   localparam int          CVST_VW        = 16;
   localparam logic [15:0] CVST_FC_MARKER = 16'h3333;
   localparam logic [15:0] CVST_CNT_RST   = 16'h0000;
   localparam logic [15:0] CVST_POS_RST   = 16'h0000;
   localparam logic [7:0]  CVST_FILL_RST  = 8'h00;
   localparam int          CVST_FIFO_DEPTH = 8;
   localparam int          CVST_TAPS      = 4;
   localparam int          CVST_MAX_PIX   = 4096;
   localparam int          CVST_BYTES_PER_WORD = 4;
   localparam int          CVST_SMALL_BYTES = 1024;
   localparam int          CVST_LARGE_BYTES = 16384;
   localparam logic [15:0] CVST_SMALL_WORDS = 16'(CVST_SMALL_BYTES / CVST_BYTES_PER_WORD);
   localparam logic [15:0] CVST_LARGE_WORDS = 16'(CVST_LARGE_BYTES / CVST_BYTES_PER_WORD);

   typedef struct packed {
      logic        interleave_en;
      logic        frame_count_en;
      logic        internal_data;
      logic        linescan;
      logic        line_valid_cont;
      logic        margin_fill_en;
      logic        small_image;
      logic        trig_frame;
      logic        trig_line;
      logic        trig_active_high;
      logic        trig_from_cc2;
      logic        fifo_reset;
   } cvst_ctrl_s;

   typedef struct packed {
      logic [15:0] width_clocks;
      logic [15:0] hblank;
      logic [15:0] total_width;
      logic [15:0] height;
      logic [15:0] vblank;
      logic [15:0] total_height;
      logic [15:0] fv_start;
      logic [15:0] fv_end;
      logic [15:0] lv_start;
      logic [15:0] lv_end;
      logic [15:0] rv_start;
      logic [15:0] rv_end;
      logic [7:0]  left_margin_value;
      logic [7:0]  right_margin_value;
   } cvst_geom_s;

   typedef struct packed {
      logic        frame_valid;
      logic        line_valid;
      logic        data_valid;
      logic [31:0] data;
   } cvst_video_s;
endpackage

// [cvst_fifo.sv]
// image word fifo with valid/ready on both sides and a fill level
`timescale 1ns/10ps
`default_nettype none
module cvst_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   input  wire logic                     clock,
   input  wire logic                     srst,
   input  wire logic                     clear,
   input  wire logic [WIDTH-1:0]         in_data,
   input  wire logic                     in_valid,
   output logic                          in_ready,
   output logic [WIDTH-1:0]              out_data,
   output logic                          out_valid,
   input  wire logic                     out_ready,
   output logic [$clog2(DEPTH+1)-1:0]    level
);
   localparam int AW = $clog2(DEPTH);
   localparam int LW = $clog2(DEPTH + 1);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   wire              do_wr = in_valid && in_ready;
   wire              do_rd = out_valid && out_ready;

   assign in_ready  = (level != ($clog2(DEPTH+1))'(DEPTH));
   assign out_valid = (level != '0);
   assign out_data  = mem[rd_ptr];

   always_ff @(posedge clock)
   begin
      if (do_wr)
      begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clock)
   begin
      if (srst || clear)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level  <= '0;
      end
      else
      begin
         if (do_wr)
         begin
            wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + AW'(1);
         end
         if (do_rd)
         begin
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + AW'(1);
         end
         level <= level + LW'(do_wr) - LW'(do_rd);
      end
   end
endmodule
`default_nettype wire

// [cvst_top_checker.sv]
// port assertions for the video source timing block
`timescale 1ns/10ps
`default_nettype none
module cvst_top_checker #(
   parameter int FIFO_DEPTH = 8,
   parameter int LEVEL_W    = 16
) (
   input  wire logic                  clock,
   input  wire logic                  srst,
   input  wire cvst_pkg::cvst_ctrl_s  ctrl,
   input  wire cvst_pkg::cvst_geom_s  geom,
   input  wire logic [LEVEL_W-1:0]    host_buffered_words,
   input  wire logic [31:0]           dma_data,
   input  wire logic                  dma_valid,
   input  wire logic                  dma_ready,
   input  wire logic                  cc1,
   input  wire logic                  cc2,
   input  wire cvst_pkg::cvst_video_s video,
   input  wire logic                  running
);
   import cvst_pkg::*;
   logic        trig_lvl;
   logic        trig_q;
   logic [7:0]  quiet;
   logic [31:0] swapped;
   logic        plain;
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   assign trig_lvl = (ctrl.trig_from_cc2 ? cc2 : cc1) == ctrl.trig_active_high;
   assign swapped = {video.data[7:0], video.data[15:8], video.data[23:16], video.data[31:24]};
   assign plain = ctrl.internal_data && !ctrl.margin_fill_en && !ctrl.interleave_en
                  && !ctrl.frame_count_en;
   // trigger age saturates, so an old edge never looks fresh
   always_ff @(posedge clock)
   begin
      trig_q <= trig_lvl;
      if (srst)
         quiet <= 8'hff;
      else if (trig_lvl && !trig_q)
         quiet <= 8'h00;
      else if (quiet != 8'hff)
         quiet <= quiet + 8'h01;
   end
   a_stop_refuse: assert property (ctrl.fifo_reset && $past(ctrl.fifo_reset) |-> !dma_ready)
      else $error("dma word accepted while stopped");
   a_stop_quiet: assert property (ctrl.fifo_reset [*2] |=> !video.data_valid && !running)
      else $error("video still running while stopped");
   a_idle_silent: assert property (!running && !$past(running) |-> !video.data_valid)
      else $error("data valid while idle");
   a_start_level: assert property ($rose(running) && !ctrl.internal_data |->
      32'(host_buffered_words) + 32'(FIFO_DEPTH) >=
      (ctrl.small_image ? 32'(CVST_SMALL_WORDS) : 32'(CVST_LARGE_WORDS)))
      else $error("started below the buffer threshold");
   a_count_inverse: assert property (video.data_valid && plain |->
      video.data[31:16] == ~video.data[15:0])
      else $error("internal word halves not inverse");
   a_count_step: assert property (video.data_valid && $past(video.data_valid) && plain |->
      video.data[15:0] == $past(video.data[15:0]) + 16'h0001)
      else $error("internal count did not step by one");
   a_swap_inverse: assert property (video.data_valid && ctrl.internal_data &&
      ctrl.interleave_en && !ctrl.margin_fill_en && video.data[31:16] != 16'h3333 |->
      swapped[31:16] == ~swapped[15:0])
      else $error("interleaved word not byte reordered");
   a_line_trig: assert property ($rose(video.line_valid) && ctrl.trig_line |->
      quiet < 8'd40)
      else $error("line started without a trigger");
   a_fv_with_data: assert property (video.data_valid && geom.fv_start == geom.lv_start &&
      geom.fv_end == geom.lv_end |-> video.frame_valid)
      else $error("data valid outside frame valid");
   a_lv_blank: assert property (video.line_valid && !video.frame_valid &&
      geom.fv_start == geom.lv_start && geom.fv_end == geom.lv_end |-> ctrl.line_valid_cont)
      else $error("line valid in vertical blanking");
endmodule
bind cvst_top cvst_top_checker #(.FIFO_DEPTH(FIFO_DEPTH), .LEVEL_W(LEVEL_W)) cvst_top_checker_inst (
   .clock(clock), .srst(srst), .ctrl(ctrl), .geom(geom),
   .host_buffered_words(host_buffered_words), .dma_data(dma_data), .dma_valid(dma_valid),
   .dma_ready(dma_ready), .cc1(cc1), .cc2(cc2), .video(video), .running(running));
`default_nettype wire

// [cvst_grabber.sv]
// frame grabber model that captures the video link
`timescale 1ns/10ps
`default_nettype none
module cvst_grabber (
   input  wire logic                  clock,
   input  wire cvst_pkg::cvst_video_s video
);
   import cvst_pkg::*;
   logic [31:0] words[$];
   int          stamps[$];
   int          lines_at[$];
   int          cycle = 0;
   int          lv_rises = 0;
   logic        lv_q = 1'b0;
   // a grabber only listens; it has no way to stall the link
   always @(posedge clock)
   begin
      cycle <= cycle + 1;
      lv_q <= video.line_valid;
      if (video.line_valid === 1'b1 && lv_q !== 1'b1)
         lv_rises <= lv_rises + 1;
      if (video.data_valid === 1'b1)
      begin
         words.push_back(video.data);
         stamps.push_back(cycle);
         lines_at.push_back(lv_rises);
      end
   end
endmodule
`default_nettype wire

// [testbench.sv]
// self-checking bench for the video source timing block
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import cvst_pkg::*;
   logic        clock;
   logic        srst;
   cvst_ctrl_s  ctrl;
   cvst_ctrl_s  base;
   cvst_geom_s  geom;
   logic [15:0] host_buffered_words;
   logic [31:0] dma_data;
   logic        dma_valid;
   logic        dma_ready;
   logic        cc1;
   logic        cc2;
   cvst_video_s video;
   logic        running;
   int          mismatches = 0;
   int          checks = 0;
   int          cycles = 0;
   cvst_top #(.FIFO_DEPTH(CVST_FIFO_DEPTH), .LEVEL_W(16)) cvst_top_inst (
      .clock(clock), .srst(srst), .ctrl(ctrl), .geom(geom),
      .host_buffered_words(host_buffered_words), .dma_data(dma_data), .dma_valid(dma_valid),
      .dma_ready(dma_ready), .cc1(cc1), .cc2(cc2), .video(video), .running(running));
   cvst_grabber cvst_grabber_inst (.clock(clock), .video(video));
   initial clock = 1'b0;
   always #2 clock = ~clock;
   // dma source holds each word until the fifo takes it
   always @(posedge clock)
   begin
      cycles++;
      if (dma_valid && dma_ready === 1'b1)
         dma_data <= dma_data + 32'h1;
      if (cycles == 30000)
      begin
         mismatches++;
         finish_test();
      end
   end
   task automatic finish_test();
      if (mismatches == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask
   function automatic logic [31:0] nw();
      return 32'(cvst_grabber_inst.words.size());
   endfunction
   task automatic stop_and_set(input cvst_ctrl_s c);
      ctrl.fifo_reset <= 1'b1;
      repeat (3) @(posedge clock);
      c.fifo_reset = 1'b1;
      ctrl <= c;
      dma_data <= 32'h0;
      repeat (3) @(posedge clock);
      cvst_grabber_inst.words.delete();
      cvst_grabber_inst.stamps.delete();
      cvst_grabber_inst.lines_at.delete();
      ctrl.fifo_reset <= 1'b0;
   endtask
   task automatic wait_words(input int n);
      for (int k = 0; k < 3000 && nw() < n; k++)
         @(posedge clock);
      check(32'(nw() >= n), 32'h1);
   endtask
   task automatic t_frame_shapes();
      // hblank, total width, vblank, total height, lv cont, linescan, period, lines
      int tbl[4][8] = '{'{4, 0, 2, 0, 0, 0, 60, 3}, '{0, 14, 2, 0, 1, 0, 70, 5},
                        '{4, 0, 0, 4, 1, 0, 48, 4}, '{4, 0, 2, 0, 0, 1, 36, 3}};
      cvst_ctrl_s c;
      foreach (tbl[i])
      begin
         c = base;
         c.internal_data = 1'b1;
         c.line_valid_cont = tbl[i][4][0];
         c.linescan = tbl[i][5][0];
         geom.hblank <= 16'(tbl[i][0]);
         geom.total_width <= 16'(tbl[i][1]);
         geom.vblank <= 16'(tbl[i][2]);
         geom.total_height <= 16'(tbl[i][3]);
         stop_and_set(c);
         wait_words(49);
         check(cvst_grabber_inst.words[0], 32'hffff0000);
         check(cvst_grabber_inst.words[1], 32'hfffe0001);
         check(32'(cvst_grabber_inst.stamps[24] - cvst_grabber_inst.stamps[0]), 32'(tbl[i][6]));
         check(32'(cvst_grabber_inst.words[24][15:0]), tbl[i][5] ? 32'h18 : 32'h0);
         check(32'(cvst_grabber_inst.lines_at[48] - cvst_grabber_inst.lines_at[24]), 32'(tbl[i][7]));
      end
   endtask
   task automatic t_options();
      cvst_ctrl_s c;
      c = base;
      c.internal_data = 1'b1;
      c.interleave_en = 1'b1;
      c.frame_count_en = 1'b1;
      stop_and_set(c);
      wait_words(25);
      check(cvst_grabber_inst.words[0], 32'h33330000);
      check(cvst_grabber_inst.words[1], 32'h0100feff);
      check(cvst_grabber_inst.words[24], 32'h33330001);
      c = base;
      c.internal_data = 1'b1;
      c.margin_fill_en = 1'b1;
      stop_and_set(c);
      wait_words(8);
      check(cvst_grabber_inst.words[0], {4{8'ha5}});
      check(cvst_grabber_inst.words[2], 32'hffff0000);
      check(cvst_grabber_inst.words[7], {4{8'h5a}});
   endtask
   task automatic t_triggers();
      cvst_ctrl_s c;
      for (int i = 0; i < 4; i++)
      begin
         c = base;
         c.internal_data = 1'b1;
         c.trig_from_cc2 = i[0];
         c.trig_active_high = i[1];
         c.trig_frame = (i == 3);
         c.trig_line = (i != 3);
         cc1 <= ~i[1];
         cc2 <= ~i[1];
         stop_and_set(c);
         repeat (60) @(posedge clock);
         check(nw(), 32'h0);
         pulse(~i[0], i[1]);
         repeat (60) @(posedge clock);
         check(nw(), 32'h0);
         pulse(i[0], i[1]);
         repeat (100) @(posedge clock);
         check(nw(), (i == 3) ? 32'h18 : 32'h8);
      end
   endtask
   task automatic pulse(input logic on_cc2, input logic lvl);
      if (on_cc2)
         cc2 <= lvl;
      else
         cc1 <= lvl;
      repeat (4) @(posedge clock);
      if (on_cc2)
         cc2 <= ~lvl;
      else
         cc1 <= ~lvl;
   endtask
   task automatic t_dma();
      cvst_ctrl_s c;
      c = base;
      c.small_image = 1'b1;
      host_buffered_words <= 16'd200;
      dma_valid <= 1'b1;
      stop_and_set(c);
      repeat (40) @(posedge clock);
      check(dma_ready, 1'b0);
      check(running, 1'b0);
      host_buffered_words <= 16'd256;
      wait_words(8);
      for (int k = 0; k < 8; k++)
         check(cvst_grabber_inst.words[k], 32'(k));
      c.small_image = 1'b0;
      host_buffered_words <= 16'd4000;
      stop_and_set(c);
      repeat (40) @(posedge clock);
      check(nw(), 32'h0);
      host_buffered_words <= 16'd4096;
      wait_words(8);
      check(running, 1'b1);
      ctrl.fifo_reset <= 1'b1;
      repeat (3) @(posedge clock);
      check(dma_ready, 1'b0);
      check(running, 1'b0);
      dma_valid <= 1'b0;
   endtask
   initial
   begin
      srst = 1'b1;
      base = '0;
      base.trig_active_high = 1'b1;
      ctrl = base;
      ctrl.fifo_reset = 1'b1;
      geom = '0;
      geom.width_clocks = 16'h0008;
      geom.height = 16'h0003;
      geom.rv_start = 16'h0002;
      geom.rv_end = 16'h0006;
      geom.left_margin_value = 8'ha5;
      geom.right_margin_value = 8'h5a;
      host_buffered_words = 16'h0;
      dma_data = 32'h0;
      dma_valid = 1'b0;
      cc1 = 1'b0;
      cc2 = 1'b0;
      repeat (10) @(posedge clock);
      srst <= 1'b0;
      t_frame_shapes();
      t_options();
      t_triggers();
      t_dma();
      finish_test();
   end
endmodule
`default_nettype wire
